// *** core/srw_consts.svh ***
/*
  srw_consts.svh: timing constants, reset values and variant choices for
  the supervisor reset / watchdog / hold block.
  Assumes a 40 MHz system clock; included by bare name.
*/
`ifndef SRW_CONSTS_SVH
`define SRW_CONSTS_SVH

// ==========================================================================
// clock and times
// ==========================================================================
`define SRW_CLK_HZ            40000000
// reset hold period in milliseconds
`define SRW_RESET_HOLD_MS     200
// watchdog period in tenths of a second
`define SRW_WATCHDOG_DS       16
// derived cycle counts (above 4096, hence top-level parameter defaults)
`define SRW_RESET_HOLD_CYC    ((`SRW_CLK_HZ / 1000) * `SRW_RESET_HOLD_MS)
`define SRW_WATCHDOG_CYC      ((`SRW_CLK_HZ / 10) * `SRW_WATCHDOG_DS)
`define SRW_CNT_W             32

// ==========================================================================
// variant: threshold tolerance below nominal, in tenths of a percent
// ==========================================================================
`define SRW_TOL_7P5           8'h4B
`define SRW_TOL_12P5          8'h7D

// ==========================================================================
// reset values
// ==========================================================================
`define SRW_SYNC_RST          1'b0
`define SRW_HOLD_SYNC_RST     1'b1

`endif

// *** core/srw_enable_hold.sv ***
/*
  srw_enable_hold: enable / self-hold control of the regulator on state.
  Assumes enable and hold levels already synchronised, pulls resolved.
*/
`timescale 1ns/1ps
`include "srw_consts.svh"
module srw_enable_hold
  import srw_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic clk_en_in,
  // controls
  input  wire logic enable_in,
  input  wire logic hold_n_in,
  // state
  output logic      reg_on_out
);
  srw_reg_state_t st_reg;
  srw_reg_state_t st_next;
  logic           on_reg;
  logic           on_next;

  always_comb begin
    st_next = st_reg;
    if (clk_en_in) begin
      case (st_reg)
        SRW_REG_OFF: begin
          if (enable_in)
            st_next = SRW_REG_ON;
        end
        SRW_REG_ON: begin
          if (!hold_n_in)
            st_next = SRW_REG_SELF;
          else if (!enable_in)
            st_next = SRW_REG_OFF;
        end
        SRW_REG_SELF: begin
          if (hold_n_in)
            st_next = enable_in ? SRW_REG_ON : SRW_REG_OFF;
        end
        default: st_next = SRW_REG_OFF;
      endcase
    end
    on_next = (st_next != SRW_REG_OFF);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_reg <= SRW_REG_OFF;
      on_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      on_reg <= on_next;
    end
  end

  assign reg_on_out = on_reg;

  self_hold_on_a: assert property (@(posedge clk_in)
    disable iff (reset_in)
    (st_reg == SRW_REG_SELF && !hold_n_in && clk_en_in) |=> on_reg)
    else $error("self hold lost on state");
  hold_no_start_a: assert property (@(posedge clk_in)
    disable iff (reset_in)
    (st_reg == SRW_REG_OFF && !enable_in) |=> !on_reg)
    else $error("hold started regulator");
endmodule

// *** core/srw_pkg.sv ***
/*
  srw_pkg: types for the supervisor reset / watchdog / hold block.
  Assumes srw_consts.svh sits alongside for the numeric constants.
*/
package srw_pkg;
  // hold -> run -> (timeout) trip -> hold; gray coded except trip -> hold (11 -> 00)
  typedef enum logic [1:0] {
    SRW_ST_HOLD = 2'b00,
    SRW_ST_RUN  = 2'b01,
    SRW_ST_TRIP = 2'b11
  } srw_state_t;

  typedef enum logic [1:0] {
    SRW_REG_OFF  = 2'b00,
    SRW_REG_ON   = 2'b01,
    SRW_REG_SELF = 2'b11
  } srw_reg_state_t;
endpackage

// *** core/srw_sync.sv ***
/*
  srw_sync: two flip-flop level synchroniser.
  Assumes asynchronous pin levels and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "srw_consts.svh"
module srw_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic clk_en_in,
  // data
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = meta_reg;
    sync_next = sync_reg;
    if (clk_en_in) begin
      meta_next = async_in;
      sync_next = meta_reg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule

// *** core/srw_top.sv ***
/*
  srw_top: supervisor reset generator, watchdog and enable/hold control.
  Assumes a free-running 40 MHz clock; undervoltage, service, enable and
  hold arrive as raw pin levels with pulls resolved by the pad; the reset
  pin is open drain, resolved outside from the output enable.
*/
`timescale 1ns/1ps
`include "srw_consts.svh"

module srw_top
  import srw_pkg::*;
#(
  parameter int unsigned RESET_HOLD_CYC = `SRW_RESET_HOLD_CYC,
  parameter int unsigned WATCHDOG_CYC   = `SRW_WATCHDOG_CYC,
  parameter logic [7:0]  THRESH_TOL     = `SRW_TOL_7P5
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       clk_en_in,
  // supervised inputs (asynchronous pins)
  input  wire logic       undervolt_in,
  input  wire logic       watchdog_service_input_in,
  // regulator control pins
  input  wire logic       enable_in,
  input  wire logic       hold_n_in,
  // open-drain reset pin
  input  wire logic       reset_pin_in,
  output logic            reset_pin_out,
  output logic            reset_pin_oe_out,
  // status
  output logic            reg_on_out,
  output logic            wd_trip_out,
  output logic [7:0]      thresh_tol_out
);
  // ========================================================================
  // synchronisers
  // ========================================================================
  logic uv_sync;
  logic wdi_sync;
  logic en_sync;
  logic hold_n_sync;

  srw_sync #(.RST_VAL(1'b1)) u_sync_uv (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .clk_en_in (clk_en_in),
    .async_in  (undervolt_in),
    .sync_out  (uv_sync)
  );
  srw_sync #(.RST_VAL(`SRW_SYNC_RST)) u_sync_wdi (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .clk_en_in (clk_en_in),
    .async_in  (watchdog_service_input_in),
    .sync_out  (wdi_sync)
  );
  srw_sync #(.RST_VAL(`SRW_SYNC_RST)) u_sync_en (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .clk_en_in (clk_en_in),
    .async_in  (enable_in),
    .sync_out  (en_sync)
  );
  srw_sync #(.RST_VAL(`SRW_HOLD_SYNC_RST)) u_sync_hold (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .clk_en_in (clk_en_in),
    .async_in  (hold_n_in),
    .sync_out  (hold_n_sync)
  );

  // ========================================================================
  // enable and hold
  // ========================================================================
  // pad pull-up gives released hold
  srw_enable_hold u_enable_hold (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .clk_en_in  (clk_en_in),
    .enable_in  (en_sync),
    .hold_n_in  (hold_n_sync),
    .reg_on_out (reg_on_out)
  );

  // ========================================================================
  // reset generator and watchdog
  // ========================================================================
  srw_state_t             st_reg;
  srw_state_t             st_next;
  logic [`SRW_CNT_W-1:0]  hold_cnt_reg;
  logic [`SRW_CNT_W-1:0]  hold_cnt_next;
  logic [`SRW_CNT_W-1:0]  wd_cnt_reg;
  logic [`SRW_CNT_W-1:0]  wd_cnt_next;
  logic                   wdi_last_reg;
  logic                   wdi_last_next;
  logic                   rst_low_reg;
  logic                   rst_low_next;
  logic                   trip_reg;
  logic                   trip_next;
  logic [7:0]             tol_reg;
  logic                   service_edge;

  assign service_edge = (wdi_sync != wdi_last_reg);

  always_comb begin
    st_next       = st_reg;
    hold_cnt_next = hold_cnt_reg;
    wd_cnt_next   = wd_cnt_reg;
    wdi_last_next = wdi_last_reg;
    trip_next     = trip_reg;
    if (clk_en_in) begin
      wdi_last_next = wdi_sync;
      case (st_reg)
        SRW_ST_HOLD: begin
          wd_cnt_next = '0;
          if (uv_sync) begin
            hold_cnt_next = '0;
          end else if (hold_cnt_reg >= RESET_HOLD_CYC - 1) begin
            hold_cnt_next = '0;
            trip_next     = 1'b0;
            st_next       = SRW_ST_RUN;
          end else begin
            hold_cnt_next = hold_cnt_reg + 1'b1;
          end
        end
        SRW_ST_RUN: begin
          if (uv_sync) begin
            wd_cnt_next = '0;
            st_next     = SRW_ST_HOLD;
          end else if (service_edge) begin
            wd_cnt_next = '0;
          end else if (wd_cnt_reg >= WATCHDOG_CYC - 1) begin
            wd_cnt_next = '0;
            st_next     = SRW_ST_TRIP;
          end else begin
            wd_cnt_next = wd_cnt_reg + 1'b1;
          end
        end
        SRW_ST_TRIP: begin
          trip_next     = 1'b1;
          hold_cnt_next = '0;
          st_next       = SRW_ST_HOLD;
        end
        default: st_next = SRW_ST_HOLD;
      endcase
    end
    // low in every state but run
    rst_low_next = (st_next != SRW_ST_RUN);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_reg       <= SRW_ST_HOLD;
      hold_cnt_reg <= '0;
      wd_cnt_reg   <= '0;
      wdi_last_reg <= 1'b0;
      rst_low_reg  <= 1'b1;
      trip_reg     <= 1'b0;
      tol_reg      <= THRESH_TOL;
    end else begin
      st_reg       <= st_next;
      hold_cnt_reg <= hold_cnt_next;
      wd_cnt_reg   <= wd_cnt_next;
      wdi_last_reg <= wdi_last_next;
      rst_low_reg  <= rst_low_next;
      trip_reg     <= trip_next;
      tol_reg      <= THRESH_TOL;
    end
  end

  assign reset_pin_out    = 1'b0;
  assign reset_pin_oe_out = rst_low_reg;
  assign wd_trip_out      = trip_reg;
  assign thresh_tol_out   = tol_reg;

  // ========================================================================
  // checks
  // ========================================================================
  sequence uv_seen_s;
    uv_sync && clk_en_in;
  endsequence

  sequence trip_enter_s;
    st_reg == SRW_ST_RUN && clk_en_in && !uv_sync && !service_edge &&
      wd_cnt_reg >= WATCHDOG_CYC - 1;
  endsequence

  sequence released_s;
    $fell(rst_low_reg);
  endsequence

  undervolt_reset_a: assert property (@(posedge clk_in)
    disable iff (reset_in) uv_seen_s |=> rst_low_reg)
    else $error("reset not low under undervoltage");

  uv_restart_a: assert property (@(posedge clk_in)
    disable iff (reset_in)
    (st_reg == SRW_ST_HOLD && uv_sync && clk_en_in) |=> hold_cnt_reg == '0)
    else $error("hold count not restarted by undervoltage");

  hold_period_a: assert property (@(posedge clk_in)
    disable iff (reset_in)
    released_s |-> $past(hold_cnt_reg) >= RESET_HOLD_CYC - 1)
    else $error("reset released before hold period");

  hold_bound_a: assert property (@(posedge clk_in)
    disable iff (reset_in) hold_cnt_reg < RESET_HOLD_CYC)
    else $error("hold count beyond period");

  startup_low_a: assert property (@(posedge clk_in)
    $fell(reset_in) |-> rst_low_reg)
    else $error("reset not low after startup");

  drain_only_a: assert property (@(posedge clk_in)
    disable iff (reset_in) !reset_pin_out)
    else $error("reset pin driven high");

  wd_trip_a: assert property (@(posedge clk_in)
    disable iff (reset_in)
    trip_enter_s |=> st_reg == SRW_ST_TRIP ##1 rst_low_reg)
    else $error("watchdog timeout did not trip");

  wd_bound_a: assert property (@(posedge clk_in)
    disable iff (reset_in) wd_cnt_reg < WATCHDOG_CYC)
    else $error("watchdog count beyond period");

  trip_hold_a: assert property (@(posedge clk_in)
    disable iff (reset_in)
    (st_reg == SRW_ST_TRIP && clk_en_in) |=>
      (st_reg == SRW_ST_HOLD && hold_cnt_reg == '0 && trip_reg))
    else $error("trip did not start full hold");

  service_ignored_a: assert property (@(posedge clk_in)
    disable iff (reset_in)
    (st_reg == SRW_ST_HOLD && clk_en_in && !uv_sync &&
     hold_cnt_reg < RESET_HOLD_CYC - 1) |=> st_reg == SRW_ST_HOLD)
    else $error("hold period cut short");

  edge_clears_a: assert property (@(posedge clk_in)
    disable iff (reset_in)
    (st_reg == SRW_ST_RUN && clk_en_in && service_edge) |=>
      wd_cnt_reg == '0)
    else $error("service edge did not clear watchdog");

  wd_stopped_a: assert property (@(posedge clk_in)
    disable iff (reset_in)
    (st_reg == SRW_ST_HOLD) |=> wd_cnt_reg == '0)
    else $error("watchdog counted during reset");

  release_clears_a: assert property (@(posedge clk_in)
    disable iff (reset_in)
    released_s |-> (!trip_reg && wd_cnt_reg == '0))
    else $error("watchdog not at zero on release");

  clk_freeze_a: assert property (@(posedge clk_in)
    disable iff (reset_in)
    !clk_en_in |=> $stable(st_reg) && $stable(wd_cnt_reg))
    else $error("state moved with clock enable low");
endmodule

// *** sim/srw_cpu_model.sv ***
/*
  srw_cpu_model: processor beside the supervisor, toggling the service pin
  and watching the resolved reset pin.
  Assumes the bench picks the mode; all changes land 2 ns after the edge.
*/
`timescale 1ns/1ps
module srw_cpu_model (
  // clock
  input  wire logic       clk_in,
  // supervisor side
  input  wire logic       reset_n_in,
  output logic            service_out,
  // scenario control: 0 idle, 1 service, 2 toggle only while in reset
  input  wire logic [1:0] mode_in,
  input  wire logic [7:0] period_in
);
  int cnt;

  initial begin
    service_out = 1'b0;
    cnt = 0;
  end

  // ==========================================================================
  // service toggling
  // ==========================================================================
  // service counted from last toggle or release
  always @(posedge clk_in) begin
    #2;
    if ((mode_in == 2'd1 && reset_n_in === 1'b1) ||
        (mode_in == 2'd2 && reset_n_in === 1'b0)) begin
      cnt = cnt + 1;
      if (cnt >= ((mode_in == 2'd2) ? 4 : int'(period_in))) begin
        service_out = ~service_out;
        cnt = 0;
      end
    end else begin
      cnt = 0;
    end
  end
endmodule

// *** sim/tb_supervisor_reset_watchdog_hold.sv ***
/*
  tb_supervisor_reset_watchdog_hold: self-checking bench for srw_top.
  Assumes shortened periods; reset pin pulled up outside the block.
*/
`timescale 1ns/1ps
module tb_supervisor_reset_watchdog_hold;
  localparam int H = 20;
  localparam int W = 50;

  logic       clk_in;
  logic       reset_in;
  logic       clk_en;
  logic       undervolt;
  logic       enable;
  logic       hold_n;
  logic       watchdog_service_input;
  logic       rst_drv;
  logic       rst_oe;
  logic       reg_on;
  logic       wd_trip;
  logic [7:0] tol;
  logic [1:0] cpu_mode;
  logic [7:0] cpu_period;
  wire        rst_pin_n;
  int         n_fail;
  int         check_count;
  int         n;

  // open drain with pull-up
  assign rst_pin_n = rst_oe ? rst_drv : 1'b1;

  srw_top #(.RESET_HOLD_CYC(H), .WATCHDOG_CYC(W)) i_dut (
    .clk_in                    (clk_in),
    .reset_in                  (reset_in),
    .clk_en_in                 (clk_en),
    .undervolt_in              (undervolt),
    .watchdog_service_input_in (watchdog_service_input),
    .enable_in                 (enable),
    .hold_n_in                 (hold_n),
    .reset_pin_in              (rst_pin_n),
    .reset_pin_out             (rst_drv),
    .reset_pin_oe_out          (rst_oe),
    .reg_on_out                (reg_on),
    .wd_trip_out               (wd_trip),
    .thresh_tol_out            (tol)
  );

  srw_cpu_model i_cpu (
    .clk_in      (clk_in),
    .reset_n_in  (rst_pin_n),
    .service_out (watchdog_service_input),
    .mode_in     (cpu_mode),
    .period_in   (cpu_period)
  );

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic in_range(input string what, input int v, input int lo,
                          input int hi);
    check(what, 8'(v), (v >= lo && v <= hi) ? 8'(v) : 8'(lo));
  endtask

  task automatic wait_oe(input logic v, input int lim, output int k);
    k = 0;
    while (rst_oe !== v && k < lim) begin
      @(negedge clk_in);
      k++;
    end
  endtask

  // counts cycles in which the reset pin is released
  task automatic count_free(input int cyc, output int k);
    k = 0;
    repeat (cyc) begin
      @(negedge clk_in);
      if (rst_oe !== 1'b1) k++;
    end
  endtask

  task automatic drive_eh(input logic en, input logic hn, input int k);
    @(posedge clk_in);
    #2;
    enable = en;
    hold_n = hn;
    repeat (k) @(negedge clk_in);
  endtask

  task automatic set_uv(input logic v);
    @(posedge clk_in);
    #2;
    undervolt = v;
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_power_up;
    repeat (30) @(negedge clk_in);
    check("oe_powerup", 8'(rst_oe), 8'h01);
    check("pin_drive", 8'(rst_drv), 8'h00);
    check("pin_level", 8'(rst_pin_n), 8'h00);
    check("tolerance", tol, 8'h4B);
    check("reg_default", 8'(reg_on), 8'h00);
  endtask

  task automatic t_uv_release;
    cpu_mode = 2'd1;
    cpu_period = 8'h14;
    set_uv(1'b0);
    wait_oe(1'b0, H + 20, n);
    in_range("uv_hold", n, H, H + 6);
    check("pin_float", 8'(rst_pin_n), 8'h01);
  endtask

  task automatic t_uv_dip;
    set_uv(1'b1);
    cpu_mode = 2'd0;
    wait_oe(1'b1, 10, n);
    in_range("uv_assert", n, 1, 4);
    count_free(2 * W, n);
    check("uv_low_free", 8'(n), 8'h00);
    check("uv_no_trip", 8'(wd_trip), 8'h00);
    set_uv(1'b0);
    wait_oe(1'b0, H + 20, n);
    in_range("dip_hold", n, H, H + 6);
  endtask

  task automatic t_wd_pattern;
    cpu_mode = 2'd2;
    repeat (3) begin
      wait_oe(1'b1, W + 20, n);
      in_range("wd_period", n, W - 1, W + 6);
      repeat (2) @(negedge clk_in);
      check("wd_trip", 8'(wd_trip), 8'h01);
      wait_oe(1'b0, H + 20, n);
      in_range("wd_hold", n, H - 3, H + 3);
    end
  endtask

  task automatic t_service;
    // both edges count: rising alone would exceed the period
    cpu_mode = 2'd1;
    cpu_period = 8'h1E;
    count_free(300, n);
    check("served_30", 8'(n == 300), 8'h01);
    cpu_period = 8'h28;
    count_free(300, n);
    check("served_40", 8'(n == 300), 8'h01);
    check("no_trip", 8'(wd_trip), 8'h00);
  endtask

  task automatic t_enable_hold;
    drive_eh(1'b0, 1'b0, 10);
    check("hold_from_off", 8'(reg_on), 8'h00);
    drive_eh(1'b1, 1'b1, 6);
    check("enable_on", 8'(reg_on), 8'h01);
    drive_eh(1'b0, 1'b1, 6);
    check("enable_off", 8'(reg_on), 8'h00);
    drive_eh(1'b1, 1'b1, 6);
    drive_eh(1'b1, 1'b0, 6);
    drive_eh(1'b0, 1'b0, 10);
    check("held_on", 8'(reg_on), 8'h01);
    drive_eh(1'b0, 1'b1, 6);
    check("hold_release", 8'(reg_on), 8'h00);
  endtask

  // frozen clock enable: no trip, no turn-on, both resume after thaw
  task automatic t_freeze;
    cpu_mode = 2'd0;
    @(posedge clk_in);
    #2;
    clk_en = 1'b0;
    drive_eh(1'b1, 1'b1, 2 * W);
    check("frozen_oe", 8'(rst_oe), 8'h00);
    check("frozen_reg", 8'(reg_on), 8'h00);
    @(posedge clk_in);
    #2;
    clk_en = 1'b1;
    repeat (4) @(negedge clk_in);
    check("thawed_reg", 8'(reg_on), 8'h01);
    wait_oe(1'b1, W + 20, n);
    in_range("thaw_trip", n, 0, W + 6);
  endtask

  // ==========================================================================
  // clock, watchdog, main sequence
  // ==========================================================================
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    give_verdict();
  end

  initial begin
    n_fail = 0;
    check_count = 0;
    reset_in = 1'b1;
    clk_en = 1'b1;
    undervolt = 1'b1;
    enable = 1'b0;
    hold_n = 1'b1;
    cpu_mode = 2'd0;
    cpu_period = 8'h14;
    repeat (16) @(posedge clk_in);
    #2;
    reset_in = 1'b0;
    t_power_up();
    t_uv_release();
    t_uv_dip();
    t_wd_pattern();
    t_service();
    t_enable_hold();
    t_freeze();
    give_verdict();
  end
endmodule
